// >>> rtl/prgseq_pkg.sv
// Shared constants for the program sequencer
package prgseq_pkg;
   localparam int PC_WIDTH_DEF = 10;                     // Counter width, smaller variants
   localparam int STACK_DEPTH_DEF = 4;                   // Return stack levels
   localparam logic [1:0] PHASE_ONE = 2'h0;              // Phase index of fetch
   localparam logic [1:0] PHASE_LAST = 2'h3;             // Final execute phase
   localparam logic [10:0] VEC_RESET = 11'h000;          // Reset entry
   localparam logic [10:0] VEC_EXT_INT = 11'h004;        // External interrupt entry
   localparam logic [10:0] VEC_TMR_INT = 11'h008;        // Timer overflow entry
   localparam logic [7:0] PCL_RESET = 8'h00;             // Low byte after reset
   // Instruction flow class given by the decoder
   typedef enum logic [5:0] {
      PRGSEQ_OP_SEQ = 6'h01,       // Sequential instruction
      PRGSEQ_OP_JUMP = 6'h02,      // Jump to code address
      PRGSEQ_OP_CALL = 6'h04,      // Call to code address
      PRGSEQ_OP_RET = 6'h08,       // Subroutine return
      PRGSEQ_OP_INTERRUPT_RETURN_OP = 6'h10,      // Interrupt return
      PRGSEQ_OP_PCLWR = 6'h20      // Write to low byte
   } prgseq_op_t;
   // Sequencer state
   typedef enum logic [2:0] {
      PRGSEQ_ST_RUN = 3'h1,        // Executing fetched word
      PRGSEQ_ST_DUMMY = 3'h2,      // Discarded slot
      PRGSEQ_ST_IRQ = 3'h4         // Interrupt acknowledge slot
   } prgseq_state_t;
endpackage : prgseq_pkg

// >>> rtl/prgseq_stack.sv
// Return address stack memory with registered read data
`timescale 1ns/10ps
module prgseq_stack #(
   parameter int WIDTH = 10,     // Entry width
   parameter int DEPTH = 4       // Number of levels
) (
   input wire logic sys_clk,                     // System clock
   input wire logic wr_en,                       // Write strobe
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,  // Write level
   input wire logic [WIDTH-1:0] wr_data,         // Write value
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,  // Read level
   output logic [WIDTH-1:0] rd_data              // Registered read value
);
   logic [WIDTH-1:0] mem [DEPTH];                // Storage, no reset needed

   // Write port
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge sys_clk) begin
      rd_data <= mem[rd_idx];
   end
endmodule // prgseq_stack

// >>> rtl/prgseq_core.sv
// Program sequencer: phases, program counter, return stack
`timescale 1ns/10ps
module prgseq_core
   import prgseq_pkg::*;
#(
   parameter int PC_WIDTH = PC_WIDTH_DEF,        // Counter width, 10 or 11
   parameter int STACK_DEPTH = STACK_DEPTH_DEF   // Levels, 2 or 4
) (
   input wire logic sys_clk,                     // System clock
   input wire logic rst,                         // Synchronous reset, high
   input wire logic rc_osc_sel,                  // RC oscillator option selected
   input wire logic [13:0] instr_data,           // Word from program memory
   input wire logic instr_valid,                 // Decoder result valid in last phase
   input wire prgseq_op_t instr_op,              // Flow class of executing word
   input wire logic [10:0] instr_target,         // Code address bits of word
   input wire logic skip_taken,                  // Skip condition met
   input wire logic [7:0] pcl_wr_data,           // Value written to low byte
   input wire logic ext_irq_req,                 // Enabled external request, latched
   input wire logic tmr_irq_req,                 // Enabled timer request, latched
   output logic [10:0] prog_addr,                // Program memory address
   output logic fetch_strobe,                    // Fetch in phase one
   output logic [13:0] instr_word,               // Word under execution
   output logic [3:0] phase_onehot,              // Current phase
   output logic decode_execute_phases,           // High in phases two to four
   output logic [7:0] pc_low_byte,               // Low byte read value
   output logic ext_irq_ack,                     // External acknowledge pulse
   output logic tmr_irq_ack,                     // Timer acknowledge pulse
   output logic stack_full,                      // All levels used
   output logic oscillator_output_pin            // Phase-one clock output
);
   localparam int IDX_W = $clog2(STACK_DEPTH);   // Index width
   localparam logic [IDX_W:0] DEPTH_CNT = (IDX_W+1)'(STACK_DEPTH); // Full count

   // Wrap an 11-bit address into the implemented range
   function automatic logic [PC_WIDTH-1:0] wrap_pc(input logic [10:0] a);
      wrap_pc = a[PC_WIDTH-1:0];
   endfunction

   logic [1:0] phase_ff;                         // Phase counter
   logic [PC_WIDTH-1:0] pc_ff;                   // Program counter
   logic [PC_WIDTH-1:0] nxt_pc;                  // Next counter
   prgseq_state_t state_ff;                      // Sequencer state
   prgseq_state_t nxt_state;                     // Next state
   logic [IDX_W:0] depth_ff;                     // Hidden stack level index
   logic [IDX_W:0] nxt_depth;                    // Next index
   logic [13:0] fetch_ff;                        // Prefetched word
   logic [13:0] instr_word_ff;                   // Executing word
   logic [10:0] prog_addr_ff;                    // Address register
   logic fetch_strobe_ff;                        // Fetch strobe register
   logic [3:0] phase_onehot_ff;                  // Phase decode register
   logic dec_ph_ff;                              // Execute phase flag
   logic [7:0] pcl_ff;                           // Low byte copy
   logic ext_ack_ff;                             // External acknowledge
   logic tmr_ack_ff;                             // Timer acknowledge
   logic full_ff;                                // Full flag register
   logic osc_ff;                                 // Phase clock output
   logic [PC_WIDTH-1:0] stk_rd;                  // Top of stack
   logic push;                                   // Push this cycle
   logic pop;                                    // Pop this cycle
   logic boot_ff;                                // High until the first edge after reset

   // Decode of the executing slot at end of phase four
   wire phase_wrap = (phase_ff == PHASE_LAST);
   wire end_cycle = phase_wrap && !boot_ff;                       // Leaving reset closes no slot
   wire run_end = end_cycle && (state_ff == PRGSEQ_ST_RUN) && instr_valid;
   wire is_full = (depth_ff == DEPTH_CNT);
   wire irq_any = ext_irq_req || tmr_irq_req;
   wire irq_go = run_end && irq_any && !is_full && (instr_op == PRGSEQ_OP_SEQ) && !skip_taken;
   wire do_call = run_end && (instr_op == PRGSEQ_OP_CALL);
   wire do_ret = run_end && ((instr_op == PRGSEQ_OP_RET) || (instr_op == PRGSEQ_OP_INTERRUPT_RETURN_OP));
   wire [PC_WIDTH-1:0] pc_inc = pc_ff + PC_WIDTH'(1);
   wire [PC_WIDTH-1:0] vec = wrap_pc(ext_irq_req ? VEC_EXT_INT : VEC_TMR_INT);
   wire [PC_WIDTH-1:0] pcl_tgt = {pc_ff[PC_WIDTH-1:8], pcl_wr_data};
   wire [IDX_W-1:0] wr_idx = depth_ff[IDX_W-1:0];                 // Wraps on overflow
   wire [IDX_W-1:0] rd_idx = IDX_W'(depth_ff - (IDX_W+1)'(1));

   // Next program counter and state, taken at end of phase four
   always_comb begin
      nxt_pc = pc_ff;
      nxt_state = state_ff;
      push = 1'b0;
      pop = 1'b0;
      if (end_cycle) begin
         unique case (state_ff)
            PRGSEQ_ST_RUN: begin
               nxt_pc = pc_inc;
               if (!instr_valid) begin
                  nxt_pc = pc_ff;                                 // Hold while decoder idle
               end else if (irq_go) begin
                  nxt_state = PRGSEQ_ST_IRQ;
                  nxt_pc = pc_ff;
               end else if (skip_taken) begin
                  nxt_state = PRGSEQ_ST_DUMMY;
               end else begin
                  unique case (instr_op)
                     PRGSEQ_OP_SEQ: nxt_state = PRGSEQ_ST_RUN;
                     PRGSEQ_OP_JUMP: begin
                        nxt_pc = wrap_pc(instr_target);
                        nxt_state = PRGSEQ_ST_DUMMY;
                     end
                     PRGSEQ_OP_CALL: begin
                        push = 1'b1;
                        nxt_pc = wrap_pc(instr_target);
                        nxt_state = PRGSEQ_ST_DUMMY;
                     end
                     PRGSEQ_OP_RET, PRGSEQ_OP_INTERRUPT_RETURN_OP: begin
                        pop = (depth_ff != '0);
                        nxt_pc = stk_rd;
                        nxt_state = PRGSEQ_ST_DUMMY;
                     end
                     PRGSEQ_OP_PCLWR: begin
                        nxt_pc = pcl_tgt;
                        nxt_state = PRGSEQ_ST_DUMMY;
                     end
                     default: nxt_state = PRGSEQ_ST_RUN;          // Illegal code runs on
                  endcase
               end
            end
            PRGSEQ_ST_DUMMY: begin
               nxt_pc = pc_inc;                                   // Fetch at target completes
               nxt_state = PRGSEQ_ST_RUN;
            end
            PRGSEQ_ST_IRQ: begin
               push = 1'b1;
               nxt_pc = vec;
               nxt_state = PRGSEQ_ST_DUMMY;
            end
            default: nxt_state = PRGSEQ_ST_RUN;
         endcase
      end
   end

   // Hidden index: push counts up (saturating), pop counts down
   assign nxt_depth = push ? (is_full ? depth_ff : depth_ff + (IDX_W+1)'(1))
                    : pop ? depth_ff - (IDX_W+1)'(1) : depth_ff;

   // Return stack storage
   prgseq_stack #(
      .WIDTH(PC_WIDTH),
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .sys_clk(sys_clk),
      .wr_en(push),
      .wr_idx(wr_idx),
      .wr_data(pc_ff),
      .rd_idx(rd_idx),
      .rd_data(stk_rd)
   );

   // Phase counter and sequencing registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase_ff <= PHASE_LAST;                                  // Release edge enters phase one
         boot_ff <= 1'b1;
         pc_ff <= wrap_pc(VEC_RESET);
         state_ff <= PRGSEQ_ST_DUMMY;                             // First fetch at zero
         depth_ff <= '0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
         boot_ff <= 1'b0;
         pc_ff <= nxt_pc;
         state_ff <= nxt_state;
         depth_ff <= nxt_depth;
      end
   end

   // Fetch in phase one, word moves to execute at cycle end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fetch_ff <= 14'h0000;
         instr_word_ff <= 14'h0000;
      end else begin
         if (phase_ff == PHASE_ONE) begin
            fetch_ff <= instr_data;
         end
         if (end_cycle) begin
            instr_word_ff <= fetch_ff;
         end
      end
   end

   // Output registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prog_addr_ff <= VEC_RESET;
         fetch_strobe_ff <= 1'b0;
         phase_onehot_ff <= 4'h0;
         dec_ph_ff <= 1'b0;
         pcl_ff <= PCL_RESET;
         ext_ack_ff <= 1'b0;
         tmr_ack_ff <= 1'b0;
         full_ff <= 1'b0;
         osc_ff <= 1'b0;
      end else begin
         prog_addr_ff <= 11'(nxt_pc);
         fetch_strobe_ff <= phase_wrap;
         phase_onehot_ff <= 4'h1 << (phase_ff + 2'h1);
         dec_ph_ff <= (phase_ff != PHASE_LAST);
         pcl_ff <= nxt_pc[7:0];
         ext_ack_ff <= end_cycle && state_ff == PRGSEQ_ST_IRQ && ext_irq_req;
         tmr_ack_ff <= end_cycle && state_ff == PRGSEQ_ST_IRQ && !ext_irq_req;
         full_ff <= (nxt_depth == DEPTH_CNT);
         osc_ff <= rc_osc_sel && phase_wrap;
      end
   end

   assign prog_addr = prog_addr_ff;
   assign fetch_strobe = fetch_strobe_ff;
   assign instr_word = instr_word_ff;
   assign phase_onehot = phase_onehot_ff;
   assign decode_execute_phases = dec_ph_ff;
   assign pc_low_byte = pcl_ff;
   assign ext_irq_ack = ext_ack_ff;
   assign tmr_irq_ack = tmr_ack_ff;
   assign stack_full = full_ff;
   assign oscillator_output_pin = osc_ff;

   // Assertions
   phase_onehot_ok_a: assert property (@(posedge sys_clk) disable iff (rst)
      !boot_ff |-> $onehot(phase_onehot)) else $error("phase not one-hot");
   phase_cycle_a: assert property (@(posedge sys_clk) disable iff (rst)
      phase_onehot == 4'h1 |=> phase_onehot == 4'h2 ##1 phase_onehot == 4'h4 ##1 phase_onehot == 4'h8)
      else $error("phase order wrong");
   fetch_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
      fetch_strobe |-> phase_onehot == 4'h1) else $error("fetch outside phase one");
   exec_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
      !boot_ff |-> decode_execute_phases == (phase_onehot != 4'h1)) else $error("execute phase flag wrong");
   osc_duty_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(oscillator_output_pin) |=> !oscillator_output_pin [*3]) else $error("osc duty wrong");
   seq_inc_a: assert property (@(posedge sys_clk) disable iff (rst)
      run_end && instr_op == PRGSEQ_OP_SEQ && !skip_taken && !irq_go |=> pc_ff == $past(pc_inc))
      else $error("sequential step not one");
   pcl_page_a: assert property (@(posedge sys_clk) disable iff (rst)
      run_end && instr_op == PRGSEQ_OP_PCLWR && !skip_taken |=>
      pc_ff[PC_WIDTH-1:8] == $past(pc_ff[PC_WIDTH-1:8]) && state_ff == PRGSEQ_ST_DUMMY)
      else $error("low byte write left page");
   skip_two_a: assert property (@(posedge sys_clk) disable iff (rst)
      run_end && skip_taken && !irq_go |=> state_ff == PRGSEQ_ST_DUMMY ##4 pc_ff == $past(pc_ff, 5) + PC_WIDTH'(2))
      else $error("skip not plus two");
   full_block_a: assert property (@(posedge sys_clk) disable iff (rst)
      run_end && irq_any && is_full |=> state_ff != PRGSEQ_ST_IRQ)
      else $error("interrupt taken on full stack");
   ret_pop_a: assert property (@(posedge sys_clk) disable iff (rst)
      do_ret && depth_ff != '0 |=> depth_ff == $past(depth_ff) - (IDX_W+1)'(1) && pc_ff == $past(stk_rd))
      else $error("return did not pop");
   vec_ext_a: assert property (@(posedge sys_clk) disable iff (rst)
      end_cycle && state_ff == PRGSEQ_ST_IRQ && ext_irq_req |=> pc_ff == wrap_pc(VEC_EXT_INT))
      else $error("external vector wrong");
   call_cov: cover property (@(posedge sys_clk) disable iff (rst) do_call);
   ret_cov: cover property (@(posedge sys_clk) disable iff (rst) do_ret);
   irq_cov: cover property (@(posedge sys_clk) disable iff (rst) irq_go);
   full_cov: cover property (@(posedge sys_clk) disable iff (rst) is_full && irq_any && run_end);
endmodule // prgseq_core

// >>> dv/prgseq_far_side.sv
// Far-side model: program memory and latched interrupt request sources
`timescale 1ns/10ps
module prgseq_far_side (
   input wire logic sys_clk,       // System clock
   input wire logic rst,           // Synchronous reset, high
   input wire logic [10:0] prog_addr, // Fetch address from the core
   input wire logic fetch_strobe,  // Fetch in phase one
   input wire logic ext_evt,       // External event pulse from the bench
   input wire logic tmr_evt,       // Timer overflow pulse from the bench
   input wire logic ext_irq_ack,   // External acknowledge from the core
   input wire logic tmr_irq_ack,   // Timer acknowledge from the core
   output logic [13:0] instr_data, // Word returned to the core
   output logic ext_irq_req,       // Latched external request
   output logic tmr_irq_req        // Latched timer request
);
   logic [13:0] stored_word; // Word held at the fetch address
   // Each address holds a word derived from it, so a wrong fetch shows
   assign stored_word = {prog_addr ^ 11'h2A5, 3'h6};
   // Outside a fetch the bus shows the inverse, so a late sample is caught
   assign instr_data = fetch_strobe ? stored_word : ~stored_word;
   // Requests stay recorded until the core acknowledges them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_irq_req <= 1'b0;
         tmr_irq_req <= 1'b0;
      end else begin
         ext_irq_req <= (ext_irq_req & ~ext_irq_ack) | ext_evt;
         tmr_irq_req <= (tmr_irq_req & ~tmr_irq_ack) | tmr_evt;
      end
   end
endmodule // prgseq_far_side

// >>> dv/tb_top.sv
// Self-checking bench for the program sequencer core
`timescale 1ns/10ps
module tb_top;
   import prgseq_pkg::*;
   localparam int PCW = 10;             // Counter width under test
   localparam int DEP = 4;              // Stack levels under test
   localparam logic [10:0] MSK = 11'h3FF; // Implemented address range
   logic sys_clk = 1'b0;                // System clock
   logic rst = 1'b1;                    // Synchronous reset
   logic rc_osc_sel = 1'b1;             // RC option
   logic [13:0] instr_data;             // Word from the memory model
   prgseq_op_t instr_op = PRGSEQ_OP_SEQ; // Flow class
   logic [10:0] instr_target = 11'h000; // Branch target
   logic skip_taken = 1'b0;             // Skip condition
   logic [7:0] pcl_wr_data = 8'h00;     // Low byte write value
   logic ext_evt = 1'b0;                // External event pulse
   logic tmr_evt = 1'b0;                // Timer event pulse
   logic ext_irq_req, tmr_irq_req, ext_irq_ack, tmr_irq_ack; // Interrupt handshake
   logic [10:0] prog_addr;              // Fetch address
   logic fetch_strobe, decode_execute_phases, stack_full, oscillator_output_pin; // Status
   logic [13:0] instr_word;             // Word under execution
   logic [3:0] phase_onehot;            // Current phase
   logic [7:0] pc_low_byte;             // Low byte read value
   int n_errors = 0;                    // Mismatches
   int num_checks = 0;                  // Comparisons
   int seed = 32'h415e;                 // Random seed
   int cnt;                             // Stack levels in use
   logic [10:0] stk [DEP];              // Reference stack
   logic [10:0] a, wf, nxt;             // Current fetch, previous fetch, next fetch
   logic pe, pt;                        // Pending requests
   // Clock at 200 MHz
   always #2.5 sys_clk = ~sys_clk;
   prgseq_core #(.PC_WIDTH(PCW), .STACK_DEPTH(DEP)) DUT (.sys_clk(sys_clk), .rst(rst), .rc_osc_sel(rc_osc_sel),
      .instr_data(instr_data), .instr_valid(1'b1), .instr_op(instr_op), .instr_target(instr_target),
      .skip_taken(skip_taken), .pcl_wr_data(pcl_wr_data), .ext_irq_req(ext_irq_req), .tmr_irq_req(tmr_irq_req),
      .prog_addr(prog_addr), .fetch_strobe(fetch_strobe), .instr_word(instr_word), .phase_onehot(phase_onehot),
      .decode_execute_phases(decode_execute_phases), .pc_low_byte(pc_low_byte), .ext_irq_ack(ext_irq_ack),
      .tmr_irq_ack(tmr_irq_ack), .stack_full(stack_full), .oscillator_output_pin(oscillator_output_pin));
   prgseq_far_side mem_irq (.sys_clk(sys_clk), .rst(rst), .prog_addr(prog_addr), .fetch_strobe(fetch_strobe),
      .ext_evt(ext_evt), .tmr_evt(tmr_evt), .ext_irq_ack(ext_irq_ack), .tmr_irq_ack(tmr_irq_ack),
      .instr_data(instr_data), .ext_irq_req(ext_irq_req), .tmr_irq_req(tmr_irq_req));
   // Verdict and end of run
   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Compare one value, four-state exact
   task automatic chk_val(input logic [13:0] got, input logic [13:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Word the memory holds at an address
   function automatic logic [13:0] exp_word(input logic [10:0] ad);
      return {ad ^ 11'h2A5, 3'h6};
   endfunction
   // Reference push, the index wraps onto level zero once full
   task automatic push(input logic [10:0] v);
      if (cnt < DEP) begin
         stk[cnt] = v;
         cnt++;
      end else begin
         stk[0] = v;
      end
   endtask
   // Wait for phase one under a bound, then check the slot start
   task automatic slot_head(input logic chk, input logic [10:0] adr, input logic ae, input logic at);
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         #1;
         k++;
      end while (phase_onehot !== 4'h1 && k < 8);
      chk_val(phase_onehot, 4'h1, "phase one");
      chk_val({fetch_strobe, decode_execute_phases}, 2'b10, "fetch strobe");
      chk_val(oscillator_output_pin, rc_osc_sel, "phase clock out");
      chk_val({ext_irq_ack, tmr_irq_ack}, {ae, at}, "acknowledge");
      if (chk) begin
         chk_val(prog_addr, adr, "fetch address");
         chk_val(pc_low_byte, adr[7:0], "low byte");
         chk_val(stack_full, cnt == DEP, "stack full");
      end
   endtask
   // Step through phases two to four
   task automatic phases(input logic wchk);
      for (int i = 1; i < 4; i++) begin
         @(posedge sys_clk);
         #1;
         ext_evt = 1'b0;
         tmr_evt = 1'b0;
         chk_val(phase_onehot, 4'h1 << i, "phase");
         chk_val({fetch_strobe, decode_execute_phases, oscillator_output_pin}, 3'b010, "phase flags");
      end
      if (wchk) chk_val(instr_word, exp_word(wf), "executing word");
   endtask
   // One instruction slot plus any dummy or acknowledge slots it causes
   task automatic run_instr(input prgseq_op_t op, input logic [10:0] tgt, input logic skp, input logic [7:0] pw,
                            input logic ee, input logic te);
      logic dmy, tk, ve;
      if (op inside {PRGSEQ_OP_RET, PRGSEQ_OP_INTERRUPT_RETURN_OP} && cnt == 0) op = PRGSEQ_OP_SEQ;
      // Only a plain instruction can carry a skip condition
      if (op != PRGSEQ_OP_SEQ) skp = 1'b0;
      instr_op = op;
      instr_target = tgt;
      skip_taken = skp;
      pcl_wr_data = pw;
      ext_evt = ee;
      tmr_evt = te;
      pe = pe | ee;
      pt = pt | te;
      phases(1'b1);
      tk = op == PRGSEQ_OP_SEQ && !skp && (pe || pt) && cnt < DEP;
      dmy = op != PRGSEQ_OP_SEQ || skp;
      ve = pe;
      case (op)
         PRGSEQ_OP_JUMP: nxt = tgt & MSK;
         PRGSEQ_OP_CALL: begin
            push(a);
            nxt = tgt & MSK;
         end
         PRGSEQ_OP_RET, PRGSEQ_OP_INTERRUPT_RETURN_OP: begin
            cnt--;
            nxt = stk[cnt];
         end
         PRGSEQ_OP_PCLWR: nxt = {a[10:8], pw};
         default: nxt = (a + 11'h001) & MSK;
      endcase
      if (tk) begin
         slot_head(1'b0, 11'h000, 1'b0, 1'b0);
         phases(1'b0);
         push(a);
         nxt = ve ? VEC_EXT_INT : VEC_TMR_INT;
         if (ve) pe = 1'b0;
         else pt = 1'b0;
      end
      if (dmy || tk) begin
         slot_head(1'b1, nxt, tk && ve, tk && !ve);
         phases(1'b0);
         wf = nxt;
         nxt = (nxt + 11'h001) & MSK;
      end else begin
         wf = a;
      end
      slot_head(1'b1, nxt, 1'b0, 1'b0);
      a = nxt;
   endtask
   // Main sequence: two runs, the second reset lands mid-run
   initial begin
      int k;
      for (int r = 0; r < 2; r++) begin
         rc_osc_sel = (r == 0);
         rst = 1'b1;
         repeat (4) @(posedge sys_clk);
         #1;
         rst = 1'b0;
         cnt = 0;
         pe = 1'b0;
         pt = 1'b0;
         slot_head(1'b1, VEC_RESET, 1'b0, 1'b0);
         phases(1'b0);
         wf = VEC_RESET;
         a = 11'h001;
         slot_head(1'b1, a, 1'b0, 1'b0);
         // Fill the stack, hold an interrupt off, overflow, then free a level
         for (int i = 0; i < 4; i++) run_instr(PRGSEQ_OP_CALL, 11'h100 + 11'(i), 0, 8'h00, 0, 0);
         run_instr(PRGSEQ_OP_SEQ, 11'h000, 0, 8'h00, 1, 0);
         run_instr(PRGSEQ_OP_CALL, 11'h2C0, 0, 8'h00, 0, 0);
         run_instr(PRGSEQ_OP_RET, 11'h000, 0, 8'h00, 0, 0);
         run_instr(PRGSEQ_OP_SEQ, 11'h000, 0, 8'h00, 0, 1);
         run_instr(PRGSEQ_OP_INTERRUPT_RETURN_OP, 11'h000, 0, 8'h00, 0, 0);
         run_instr(PRGSEQ_OP_JUMP, 11'h7FE, 0, 8'h00, 0, 0);
         for (int i = 0; i < 2; i++) run_instr(PRGSEQ_OP_SEQ, 11'h000, 1, 8'h00, 0, 0);
         run_instr(PRGSEQ_OP_PCLWR, 11'h000, 0, 8'hFF, 0, 0);
         for (int n = 0; n < 150; n++) begin
            k = $unsigned($random(seed)) % 6;
            run_instr(prgseq_op_t'(6'h01 << k), 11'($random(seed)), ($random(seed) & 3) == 0,
                      8'($random(seed)), ($random(seed) & 7) == 0, ($random(seed) & 7) == 0);
         end
      end
      end_sim();
   end
   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule // tb_top
